// ===== sg_defines.svh
/*
 * Register map, field positions and divider constants for the sound generator.
 * Assumes inclusion by bare name from the divider and top-level design modules.
 */
// How it works
// - tone = clock / 16 / 12-bit period
// - period = coarse low nibble, fine byte
// - noise = clock / 16 / 5-bit period
// - mixer enable bits active low
// - bits 2..0 tone, 5..3 noise enables
// - channel mixes neither, either or both
// - amplitude registers bits 4..0 per channel
// - fixed amplitude or envelope amplitude per channel
// - converter input takes one of 16 levels
// - envelope = clock / 256 / 16-bit period
// - envelope period = coarse high, fine low
// - further divide by 16, 4-bit count output
// - shape bits 3..0 select direction, repeat
// - continue3 attack2 alternate1 hold0 bit order
// - sixteen states span one envelope period
`ifndef SG_DEFINES_SVH
`define SG_DEFINES_SVH
`define SG_IDX_TONE_FINE_A 4'h0
`define SG_IDX_TONE_COARSE_A 4'h1
`define SG_IDX_TONE_FINE_B 4'h2
`define SG_IDX_TONE_COARSE_B 4'h3
`define SG_IDX_TONE_FINE_C 4'h4
`define SG_IDX_TONE_COARSE_C 4'h5
`define SG_IDX_NOISE_PERIOD 4'h6
`define SG_IDX_MIXER_ENABLE 4'h7
`define SG_IDX_AMPLITUDE_A 4'h8
`define SG_IDX_AMPLITUDE_B 4'h9
`define SG_IDX_AMPLITUDE_C 4'ha
`define SG_IDX_ENVELOPE_FINE 4'hb
`define SG_IDX_ENVELOPE_COARSE 4'hc
`define SG_IDX_ENVELOPE_SHAPE 4'hd
`define SG_IDX_LAST 4'hd
`define SG_REG_RESET 8'h00
`define SG_PRE_TONE_LAST 4'hf
`define SG_PRE_ENV_LAST 8'hff
`define SG_ENV_STEP_LAST 4'hf
`define SG_NOISE_NIBBLE_SHIFT 4
`define SG_MIX_NOISE_LSB 3
`define SG_AMP_MODE_BIT 4
`define SG_SHAPE_CONT 3
`define SG_SHAPE_ATT 2
`define SG_SHAPE_ALT 1
`define SG_SHAPE_HOLD 0
`define SG_LFSR_SEED 17'h00001
`endif

// ===== sg_pkg.sv
/*
 * Shared types for the sound generator.
 * Takes nothing from sg_defines.svh; its state codes are written literally.
 */
package sg_pkg;
	typedef enum logic [2:0] {
		SG_ENV_RUN = 3'b001,
		SG_ENV_HOLD = 3'b010,
		SG_ENV_IDLE = 3'b100
	} sg_env_state_t;
	typedef logic [7:0] sg_byte_t;
endpackage : sg_pkg

// ===== sg_div_if.sv
/*
 * Carrier between the top and one programmable divider.
 * Assumes one clock domain shared by both ends.
 */
interface sg_div_if #(parameter int W = 12);
	logic [W-1:0] period;
	logic tick;
	logic pulse;
	modport owner (output period, output tick, input pulse);
	modport div (input period, input tick, output pulse);
endinterface : sg_div_if

// ===== sg_divider.sv
/*
 * Programmable up-counter: one pulse per period ticks.
 * Assumes tick is a one-cycle enable from a prescaler on the same clock.
 */
`include "sg_defines.svh"
module sg_divider #(
	parameter int W = 12
) (
	input wire logic clock,
	input wire logic arst_n,
	input wire logic ce,
	sg_div_if.div dv
);
	logic [W-1:0] cnt_ff;
	logic pulse_ff;

	// Count ticks; period zero behaves as one
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			cnt_ff <= '0;
			pulse_ff <= 1'b0;
		end else if (ce) begin
			pulse_ff <= 1'b0;
			if (dv.tick) begin
				if (cnt_ff + W'(1) >= dv.period) begin
					cnt_ff <= '0;
					pulse_ff <= 1'b1;
				end else begin
					cnt_ff <= cnt_ff + W'(1);
				end
			end
		end
	end
	assign dv.pulse = pulse_ff;
endmodule : sg_divider

// ===== sg_sound_generator.sv
/*
 * Three-channel tone, noise and envelope sound generator with an APB register bank.
 * Assumes an APB master on the same clock; levels feed external converters.
 */
`include "sg_defines.svh"
module sg_sound_generator (
	input wire logic clock,
	input wire logic arst_n,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic [3:0] level_a,
	output logic [3:0] level_b,
	output logic [3:0] level_c,
	output logic [3:0] envelope_count,
	output logic noise_out
);
	localparam int NREG = 14;
	sg_pkg::sg_byte_t regs_ff [NREG];
	logic [31:0] prdata_ff;
	logic pready_ff;
	logic pslverr_ff;
	logic [3:0] idx;
	logic mapped;
	logic access;

	// Register index from aligned byte address
	assign idx = paddr[5:2];
	assign mapped = (paddr[31:6] == 26'h0) && (idx <= `SG_IDX_LAST);
	assign access = psel && !penable;

	// APB answer one cycle after setup; unmapped gives error
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			pready_ff <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff <= 32'h0;
		end else if (ce) begin
			pready_ff <= access;
			pslverr_ff <= access && !mapped;
			prdata_ff <= (access && !pwrite && mapped) ? {24'h0, regs_ff[idx]} : 32'h0;
		end
	end

	// Register writes at the setup cycle of a mapped write
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			for (int i = 0; i < NREG; i++) begin
				regs_ff[i] <= `SG_REG_RESET;
			end
		end else if (ce && access && pwrite && mapped) begin
			regs_ff[idx] <= pwdata[7:0];
		end
	end
	assign prdata = prdata_ff;
	assign pready = pready_ff;
	assign pslverr = pslverr_ff;

	// Prescalers: divide by 16 and by 256
	logic [7:0] pre_ff;
	logic tick16;
	logic tick256;
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			pre_ff <= 8'h00;
		end else if (ce) begin
			pre_ff <= pre_ff + 8'h01;
		end
	end
	assign tick16 = (pre_ff[3:0] == `SG_PRE_TONE_LAST);
	assign tick256 = (pre_ff == `SG_PRE_ENV_LAST);

	// Tone period from fine byte and coarse low nibble
	function automatic logic [11:0] tone_of(input sg_pkg::sg_byte_t f, input sg_pkg::sg_byte_t c);
		tone_of = {c[3:0], f};
	endfunction : tone_of

	logic [2:0] tone_sq_ff;
	logic [2:0] tone_pulse;
	genvar g;
	generate
		for (g = 0; g < 3; g++) begin : g_tone
			sg_div_if #(.W(12)) tif ();
			assign tif.period = tone_of(regs_ff[2*g], regs_ff[2*g+1]);
			assign tif.tick = tick16;
			sg_divider #(.W(12)) u_div (
				.clock(clock),
				.arst_n(arst_n),
				.ce(ce),
				.dv(tif)
			);
			assign tone_pulse[g] = tif.pulse;
			// Square wave toggles on each divider pulse
			always_ff @(posedge clock or negedge arst_n) begin
				if (!arst_n) begin
					tone_sq_ff[g] <= 1'b0;
				end else if (ce && tone_pulse[g]) begin
					tone_sq_ff[g] <= ~tone_sq_ff[g];
				end
			end
		end
	endgenerate

	// Noise divider and shift register sequence
	sg_div_if #(.W(5)) nif ();
	assign nif.period = regs_ff[`SG_IDX_NOISE_PERIOD][4:0];
	assign nif.tick = tick16;
	sg_divider #(.W(5)) u_noise_div (
		.clock(clock),
		.arst_n(arst_n),
		.ce(ce),
		.dv(nif)
	);
	logic [16:0] lfsr_ff;
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			lfsr_ff <= `SG_LFSR_SEED;
		end else if (ce && nif.pulse) begin
			lfsr_ff <= {lfsr_ff[0] ^ lfsr_ff[3], lfsr_ff[16:1]};
		end
	end

	// Envelope divider: 256 prescale, 16-bit period, then 16 steps
	logic [15:0] env_period;
	logic [11:0] env_step_period;
	assign env_period = {regs_ff[`SG_IDX_ENVELOPE_COARSE], regs_ff[`SG_IDX_ENVELOPE_FINE]};
	assign env_step_period = (env_period[15:4] == 12'h0) ? 12'h001 : env_period[15:4];
	sg_div_if #(.W(12)) eif ();
	assign eif.period = env_step_period;
	assign eif.tick = tick256;
	sg_divider #(.W(12)) u_env_div (
		.clock(clock),
		.arst_n(arst_n),
		.ce(ce),
		.dv(eif)
	);

	// Shape write restarts the envelope
	logic shape_wr;
	assign shape_wr = access && pwrite && mapped && (idx == `SG_IDX_ENVELOPE_SHAPE);
	logic [3:0] shape;
	assign shape = regs_ff[`SG_IDX_ENVELOPE_SHAPE][3:0];

	sg_pkg::sg_env_state_t env_st_ff;
	logic [3:0] step_ff;
	logic up_ff;
	logic [3:0] env_val;

	// Envelope state machine: direction, repeat, hold
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			env_st_ff <= sg_pkg::SG_ENV_IDLE;
			step_ff <= 4'h0;
			up_ff <= 1'b0;
		end else if (ce) begin
			if (shape_wr) begin
				env_st_ff <= sg_pkg::SG_ENV_RUN;
				step_ff <= 4'h0;
				up_ff <= pwdata[`SG_SHAPE_ATT];
			end else if (eif.pulse) begin
				case (env_st_ff)
					sg_pkg::SG_ENV_RUN: begin
						step_ff <= step_ff + 4'h1;
						if (step_ff == `SG_ENV_STEP_LAST) begin
							if (!shape[`SG_SHAPE_CONT]) begin
								env_st_ff <= sg_pkg::SG_ENV_IDLE;
							end else if (shape[`SG_SHAPE_HOLD]) begin
								env_st_ff <= sg_pkg::SG_ENV_HOLD;
								up_ff <= up_ff ^ shape[`SG_SHAPE_ALT];
							end else if (shape[`SG_SHAPE_ALT]) begin
								up_ff <= ~up_ff;
							end
						end
					end
					sg_pkg::SG_ENV_HOLD: begin
						env_st_ff <= sg_pkg::SG_ENV_HOLD;
					end
					sg_pkg::SG_ENV_IDLE: begin
						env_st_ff <= sg_pkg::SG_ENV_IDLE;
					end
					default: begin
						env_st_ff <= sg_pkg::SG_ENV_IDLE;
					end
				endcase
			end
		end
	end

	// Envelope value per state
	always_comb begin
		case (env_st_ff)
			sg_pkg::SG_ENV_RUN: env_val = up_ff ? step_ff : ~step_ff;
			sg_pkg::SG_ENV_HOLD: env_val = up_ff ? 4'hf : 4'h0;
			sg_pkg::SG_ENV_IDLE: env_val = 4'h0;
			default: env_val = 4'h0;
		endcase
	end

	// Mixer and amplitude select per channel
	logic [3:0] lvl [3];
	generate
		for (g = 0; g < 3; g++) begin : g_mix
			logic tone_dis;
			logic noise_dis;
			logic gate;
			sg_pkg::sg_byte_t amp;
			assign tone_dis = regs_ff[`SG_IDX_MIXER_ENABLE][g];
			assign noise_dis = regs_ff[`SG_IDX_MIXER_ENABLE][`SG_MIX_NOISE_LSB + g];
			assign gate = (tone_sq_ff[g] | tone_dis) & (lfsr_ff[0] | noise_dis);
			assign amp = regs_ff[`SG_IDX_AMPLITUDE_A + g];
			assign lvl[g] = !gate ? 4'h0 : (amp[`SG_AMP_MODE_BIT] ? env_val : amp[3:0]);
		end
	endgenerate

	// Registered outputs
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			level_a <= 4'h0;
			level_b <= 4'h0;
			level_c <= 4'h0;
			envelope_count <= 4'h0;
			noise_out <= 1'b0;
		end else if (ce) begin
			level_a <= lvl[0];
			level_b <= lvl[1];
			level_c <= lvl[2];
			envelope_count <= env_val;
			noise_out <= lfsr_ff[0];
		end
	end
endmodule : sg_sound_generator

// ===== sg_sound_generator_properties.sv
/* Port checker for the sound generator.
 Assumes ce is low only while no transfer is open. */
module sg_sound_generator_properties (
	input wire logic clock,
	input wire logic arst_n,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [3:0] level_a,
	input wire logic [3:0] level_b,
	input wire logic [3:0] level_c,
	input wire logic [3:0] envelope_count,
	input wire logic noise_out
);
	default clocking @(posedge clock); endclocking
	default disable iff (!arst_n);
	// Address outside the register bank
	wire bad_addr = paddr > 32'h37;
	a_ready_setup: assert property (ce && psel && !penable |=> pready) else $error("no ready after setup");
	a_ready_access: assert property (pready |-> psel && penable) else $error("ready outside access");
	a_err_bad: assert property (psel && !penable && bad_addr |=> pslverr) else $error("bad address taken");
	a_err_good: assert property (psel && !penable && !bad_addr |=> !pslverr) else $error("good address refused");
	a_err_data: assert property (pslverr |-> pready && prdata == 32'h0) else $error("error data not zero");
	a_write_data: assert property (pready && pwrite |-> prdata == 32'h0) else $error("write data not zero");
	a_upper_zero: assert property (pready |-> prdata[31:8] == 24'h0) else $error("upper read bits set");
	a_noise_slow: assert property ($changed(noise_out) |=> $stable(noise_out)[*8]) else $error("noise too fast");
	a_ce_freeze: assert property (!ce |=> $stable({level_a, level_b, level_c, envelope_count, noise_out})) else $error("outputs moved while frozen");
	// Main scenarios
	c_write: cover property (pready && pwrite && !pslverr);
	c_read: cover property (pready && !pwrite && !pslverr);
	c_error: cover property (pslverr);
	c_env_top: cover property (envelope_count == 4'hf);
endmodule : sg_sound_generator_properties

bind sg_sound_generator sg_sound_generator_properties u_props (.clock(clock), .arst_n(arst_n), .ce(ce),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .level_a(level_a), .level_b(level_b), .level_c(level_c),
	.envelope_count(envelope_count), .noise_out(noise_out));

// ===== sg_cpu_model.sv
/* Control processor model: APB master loading the registers.
 Assumes the sound generator answers on the same clock. */
module sg_cpu_model (
	input wire logic clock,
	input wire logic pready,
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [31:0] paddr,
	output logic [31:0] pwdata
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		{psel, penable, pwrite, paddr, pwdata} = '0;
	end
	// One transfer, held until pready is sampled high
	task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d, output logic ok);
		int n;
		@(posedge clock);
		{psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
		@(posedge clock);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clock);
			n++;
		end while (pready !== 1'b1 && n < 64);
		ok = (pready === 1'b1);
		{psel, penable} <= 2'b00;
		paddr <= ~a; // Released bus shows no stale value
		pwdata <= ~d;
	endtask : xfer
endmodule : sg_cpu_model

// ===== sg_sound_generator_tb.sv
/* Self-checking bench for the sound generator.
 Assumes the design files and checker are compiled first. */
module sg_sound_generator_tb;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct packed {logic err; logic [31:0] data;} sg_exp_t;
	logic clock, arst_n, psel, penable, pwrite, pready, pslverr, noise_out;
	logic [31:0] paddr, pwdata, prdata, seed = 32'h33;
	logic [31:0] d [14];
	logic [3:0] level_a, level_b, level_c, envelope_count;
	logic [7:0] shp [6] = '{8'h00, 8'h40, 8'h90, 8'hbf, 8'hdf, 8'hf0};
	int errors = 0, samples_checked = 0, zeros;
	logic ce = 1'b1, nprev;
	logic [3:0] held;
	sg_exp_t expq[$];
	sg_sound_generator u_dut (.clock(clock), .arst_n(arst_n), .ce(ce), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .level_a(level_a), .level_b(level_b), .level_c(level_c),
		.envelope_count(envelope_count), .noise_out(noise_out));
	sg_cpu_model u_cpu (.clock(clock), .pready(pready), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata));
	initial begin
		clock = 1'b0;
		forever #2 clock = ~clock;
	end
	function logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : xs
	task automatic chk(input string nm, input logic [32:0] e, input logic [32:0] g);
		samples_checked++;
		if (e !== g) begin
			errors++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	// Transfer with its expected answer queued
	task automatic acc(input logic w, input logic [31:0] a, input logic [31:0] v, input sg_exp_t e);
		logic ok;
		expq.push_back(e);
		u_cpu.xfer(w, a, v, ok);
		if (!ok) begin
			errors++;
			test_done();
		end
	endtask : acc
	task automatic test_done();
		errors += expq.size();
		$display("checks %0d errors %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : test_done
	// Answer monitor
	always @(posedge clock) begin
		if (pready === 1'b1) begin
			if (expq.size() == 0) begin
				errors++;
				$display("wrong value apb answer expected none seen %h", {pslverr, prdata});
			end else chk("apb answer", expq.pop_front(), {pslverr, prdata});
		end
	end
	initial begin
		repeat (40000) @(posedge clock);
		errors++;
		test_done();
	end
	initial begin
		arst_n = 1'b0;
		repeat (10) @(posedge clock);
		arst_n <= 1'b1;
		for (int i = 0; i < 14; i++) begin
			d[i] = xs();
			acc(1'b1, 4 * i, d[i], '0);
		end
		for (int i = 0; i < 14; i++) acc(1'b0, 4 * i, 0, {9'h0, 16'h0, d[i][7:0]});
		acc(1'b1, 32'h38, xs(), {1'b1, 32'h0});
		acc(1'b0, 32'h06, 0, {9'h0, 16'h0, d[1][7:0]});
		acc(1'b0, 32'h3c, 0, {1'b1, 32'h0});
		// Fixed levels, envelope on C, mixer paths off
		acc(1'b1, 32'h1c, 32'hff, '0);
		acc(1'b1, 32'h20, 32'he9, '0);
		acc(1'b1, 32'h24, 32'h06, '0);
		acc(1'b1, 32'h28, 32'h1f, '0);
		repeat (4) @(posedge clock);
		chk("level_a", 9, level_a);
		chk("level_b", 6, level_b);
		// Tone A alone, period 1 with junk coarse bits
		acc(1'b1, 32'h00, 32'h01, '0);
		acc(1'b1, 32'h04, 32'hf0, '0);
		acc(1'b1, 32'h1c, 32'h3e, '0);
		zeros = 0;
		repeat (64) @(posedge clock) zeros += (level_a == 4'h0);
		chk("tone low", 32, zeros);
		// Noise period 1 with junk upper bits: one shift per 16 clocks
		acc(1'b1, 32'h18, 32'he1, '0);
		zeros = 0;
		nprev = noise_out;
		repeat (320) begin
			@(posedge clock);
			zeros += (noise_out != nprev);
			nprev = noise_out;
		end
		chk("noise changes", 1, zeros inside {[1:20]});
		// Envelope period 16, one shape per pass
		acc(1'b1, 32'h2c, 32'h10, '0);
		acc(1'b1, 32'h30, 32'h00, '0);
		foreach (shp[k]) begin
			acc(1'b1, 32'h34, {28'hf, shp[k][7:4]}, '0);
			repeat (2048) @(posedge clock);
			chk("envelope mid", 1, envelope_count inside {[6:9]});
			// Clock enable low freezes the running envelope
			ce <= 1'b0;
			repeat (2) @(posedge clock);
			held = envelope_count;
			repeat (300) @(posedge clock);
			chk("ce freeze", held, envelope_count);
			ce <= 1'b1;
			repeat (2560) @(posedge clock);
			chk("envelope end", shp[k][3:0], envelope_count);
			chk("level_c", shp[k][3:0], level_c);
		end
		test_done();
	end
endmodule : sg_sound_generator_tb
